// [src/pump_config_bank.sv]
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`include "pump_params.svh"

module pump_config_bank #(
  parameter int ADDR_W = 10
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   ext_mode,
  output pump_pkg::code_t        pump_up_code,
  output pump_pkg::code_t        pump_down_code,
  output pump_pkg::mult_t        pump_multiplier,
  output pump_pkg::current_t     loop_current,
  output logic                   pump_up_off,
  output logic                   pump_down_off,
  output logic                   pump_code_mismatch
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pump_pkg::bank_state_s state_reg;
  pump_pkg::bank_state_s state_next;
  pump_if                pif ();

  logic [7:0]  reg_index;
  logic        setup_phase;
  logic        write_done;
  logic        hit;
  logic [15:0] read_word;
  logic [15:0] status_word;

  // ----------------------------------------------------------------
  // Field selection per mode
  // ----------------------------------------------------------------
  // Only the active set reaches the pump; the other set is held but unused
  always_comb begin
    pif.ext_mode = state_reg.mode_register[`MODE_EXT_BIT];
    if (pif.ext_mode) begin
      pif.up_code    = state_reg.external_pump_config[`EXT_UP_MSB:`EXT_UP_LSB];
      pif.down_code  = state_reg.ext_down_code_register[`EXT_DOWN_MSB:`EXT_DOWN_LSB];
      pif.multiplier = state_reg.external_pump_config[`EXT_MULT_MSB:`EXT_MULT_LSB];
    end else begin
      pif.up_code    = state_reg.internal_pump_config[`INT_UP_MSB:`INT_UP_LSB];
      pif.down_code  = state_reg.external_pump_config[`INT_DOWN_MSB:`INT_DOWN_LSB];
      pif.multiplier = state_reg.internal_pump_config[`INT_MULT_MSB:`INT_MULT_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Pump stage
  // ----------------------------------------------------------------
  // Registered stage keeps the pump outputs free of decode glitches
  pump_current_calc u_calc (
    .pclk    (pclk),
    .presetn (presetn),
    .pif     (pif.calc)
  );

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // Mismatch is reported, not corrected: keeping codes equal is software's job
  always_comb begin
    status_word        = '0;
    status_word[9:0]   = pif.result.loop_current;
    status_word[10]    = pif.ext_mode;
    status_word[11]    = pif.result.code_mismatch;
    status_word[12]    = pif.result.up_off;
    status_word[13]    = pif.result.down_off;
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  always_comb begin
    reg_index   = paddr[ADDR_W-1:2];
    setup_phase = psel && !penable;
    // Store only at the access edge that the master samples
    write_done  = psel && penable && state_reg.pready && pwrite;
    unique case (reg_index)
      `IDX_INT_PUMP_CONFIG: begin
        hit       = 1'b1;
        read_word = state_reg.internal_pump_config;
      end
      `IDX_EXT_PUMP_CONFIG: begin
        hit       = 1'b1;
        read_word = state_reg.external_pump_config;
      end
      `IDX_EXT_DOWN_CODE: begin
        hit       = 1'b1;
        read_word = state_reg.ext_down_code_register;
      end
      `IDX_PUMP_STATUS: begin
        hit       = 1'b1;
        read_word = status_word;
      end
      `IDX_PUMP_MODE: begin
        hit       = 1'b1;
        read_word = state_reg.mode_register;
      end
      default: begin
        hit       = 1'b0;
        read_word = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // One wait-free access phase: ready rises for the cycle after setup
    state_next.pready = setup_phase;
    if (setup_phase) begin
      state_next.pslverr = !hit;
      // Word taken at setup, so the access needs no wait
      state_next.prdata  = pwrite ? 32'h0000_0000 : {16'h0000, read_word};
    end else begin
      state_next.pslverr = 1'b0;
      state_next.prdata  = '0;
    end
    // Reserved bits of the three config registers are stored as written; software keeps them at fixed values
    if (write_done && hit) begin
      unique case (reg_index)
        `IDX_INT_PUMP_CONFIG: begin
          state_next.internal_pump_config = pwdata[15:0];
        end
        `IDX_EXT_PUMP_CONFIG: begin
          state_next.external_pump_config = pwdata[15:0];
        end
        `IDX_EXT_DOWN_CODE: begin
          state_next.ext_down_code_register = pwdata[15:0];
        end
        `IDX_PUMP_MODE: begin
          // Only the mode bit is kept; the rest reads zero
          state_next.mode_register = {15'h0000, pwdata[`MODE_EXT_BIT]};
        end
        `IDX_PUMP_STATUS: begin
          // Read-only: write accepted and dropped
          state_next.mode_register = state_reg.mode_register;
        end
        default: begin
          state_next.mode_register = state_reg.mode_register;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.internal_pump_config   <= `RST_INT_PUMP_CONFIG;
      state_reg.external_pump_config   <= `RST_EXT_PUMP_CONFIG;
      state_reg.ext_down_code_register <= `RST_EXT_DOWN_CODE;
      state_reg.mode_register          <= `RST_PUMP_MODE;
      state_reg.prdata                 <= '0;
      state_reg.pready                 <= 1'b0;
      state_reg.pslverr                <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // software keeps even codes
  assign prdata             = state_reg.prdata;
  assign pready             = state_reg.pready;
  assign pslverr            = state_reg.pslverr;
  assign ext_mode           = state_reg.mode_register[`MODE_EXT_BIT];
  // Pump outputs lag a register write by one edge
  assign pump_up_code       = pif.result.up_code;
  assign pump_down_code     = pif.result.down_code;
  assign pump_multiplier    = pif.result.multiplier;
  assign loop_current       = pif.result.loop_current;
  assign pump_up_off        = pif.result.up_off;
  assign pump_down_off      = pif.result.down_off;
  assign pump_code_mismatch = pif.result.code_mismatch;

endmodule // pump_config_bank

// [src/pump_params.svh]
`ifndef PUMP_PARAMS_SVH
`define PUMP_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_INT_PUMP_CONFIG   8'h28
`define IDX_EXT_PUMP_CONFIG   8'h29
`define IDX_EXT_DOWN_CODE     8'h2a
`define IDX_PUMP_STATUS       8'h2b
`define IDX_PUMP_MODE         8'h2c

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_INT_PUMP_CONFIG   16'h101c
`define RST_EXT_PUMP_CONFIG   16'h0810
`define RST_EXT_DOWN_CODE     16'h0210
`define RST_PUMP_MODE         16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EXT_UP_MSB            11
`define EXT_UP_LSB            7
`define EXT_MULT_MSB          6
`define EXT_MULT_LSB          5
`define INT_DOWN_MSB          4
`define INT_DOWN_LSB          0
`define INT_UP_MSB            12
`define INT_UP_LSB            8
`define INT_MULT_MSB          7
`define INT_MULT_LSB          6
`define EXT_DOWN_MSB          4
`define EXT_DOWN_LSB          0
`define MODE_EXT_BIT          0

// ----------------------------------------------------------------
// Multipliers in quarter steps: 1x, 2x, 1.5x, 2.5x
// ----------------------------------------------------------------
`define MULT_Q_CODE0          4'h4
`define MULT_Q_CODE1          4'h8
`define MULT_Q_CODE2          4'h6
`define MULT_Q_CODE3          4'ha

`define PUMP_CODE_OFF         5'h00

`endif

// [src/pump_pkg.sv]
package pump_pkg;

  typedef logic [4:0] code_t;
  typedef logic [1:0] mult_t;
  typedef logic [9:0] current_t;

  // Selected pump settings and derived current
  typedef struct packed {
    code_t    up_code;
    code_t    down_code;
    mult_t    multiplier;
    current_t loop_current;
    logic     up_off;
    logic     down_off;
    logic     code_mismatch;
  } calc_state_s;

  typedef struct packed {
    logic [15:0] internal_pump_config;
    logic [15:0] external_pump_config;
    logic [15:0] ext_down_code_register;
    logic [15:0] mode_register;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } bank_state_s;

endpackage

// [src/pump_if.sv]
`timescale 1ns/10ps

interface pump_if;
  logic               ext_mode;
  pump_pkg::code_t    up_code;
  pump_pkg::code_t    down_code;
  pump_pkg::mult_t    multiplier;
  pump_pkg::calc_state_s result;

  modport bank (output ext_mode, output up_code, output down_code,
                output multiplier, input result);
  modport calc (input ext_mode, input up_code, input down_code,
                input multiplier, output result);
endinterface // pump_if

// [src/pump_current_calc.sv]
`timescale 1ns/10ps
`include "pump_params.svh"

module pump_current_calc (
  input  wire logic pclk,
  input  wire logic presetn,
  pump_if.calc      pif
);

  pump_pkg::calc_state_s state_reg;
  pump_pkg::calc_state_s state_next;
  logic [3:0]            mult_q;
  logic [5:0]            base_sum;

  always_comb begin
    unique case (pif.multiplier)
      2'h0: mult_q = `MULT_Q_CODE0;
      2'h1: mult_q = `MULT_Q_CODE1;
      2'h2: mult_q = `MULT_Q_CODE2;
      2'h3: mult_q = `MULT_Q_CODE3;
    endcase
    base_sum = {1'b0, pif.up_code} + {1'b0, pif.down_code};
    state_next            = state_reg;
    state_next.up_code    = pif.up_code;
    state_next.down_code  = pif.down_code;
    state_next.multiplier = pif.multiplier;
    state_next.loop_current = {4'h0, base_sum} * {6'h0, mult_q};
    state_next.up_off     = (pif.up_code == `PUMP_CODE_OFF);
    state_next.down_off   = (pif.down_code == `PUMP_CODE_OFF);
    state_next.code_mismatch = (pif.up_code != pif.down_code);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pif.result = state_reg;

endmodule // pump_current_calc

// [testbench/pump_bank_asserts.sv]
`timescale 1ns/10ps
`include "pump_params.svh"

module pump_bank_asserts #(
  parameter int ADDR_W = 10
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [ADDR_W-1:0]  paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               ext_mode,
  input wire pump_pkg::code_t    pump_up_code,
  input wire pump_pkg::code_t    pump_down_code,
  input wire pump_pkg::mult_t    pump_multiplier,
  input wire pump_pkg::current_t loop_current,
  input wire logic               pump_up_off,
  input wire logic               pump_down_off,
  input wire logic               pump_code_mismatch
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Quarter-step gain, independent of the design tables
  function automatic logic [3:0] gq(input logic [1:0] m);
    case (m)
      2'h0: return 4'h4;
      2'h1: return 4'h8;
      2'h2: return 4'h6;
      default: return 4'ha;
    endcase
  endfunction

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence wr_mode_s;
    psel && penable && pready && pwrite && paddr[ADDR_W-1:2] == `IDX_PUMP_MODE;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_READY_AFTER_SETUP: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  AST_READY_CAUSE: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_IDLE_QUIET: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside access");
  AST_UPPER_ZERO: assert property (pready && !pslverr |-> prdata[31:16] == 16'h0)
    else $error("upper half not zero");
  // Guard skips the edge where the pump stage still shows its reset zeros
  AST_OFF_FLAGS: assert property ($past(presetn) |->
    pump_up_off == (pump_up_code == 5'h0) && pump_down_off == (pump_down_code == 5'h0))
    else $error("tri-state flag wrong");
  AST_MISMATCH: assert property ($past(presetn) |->
    pump_code_mismatch == (pump_up_code != pump_down_code))
    else $error("code mismatch flag wrong");
  AST_LOOP: assert property ($past(presetn) |->
    loop_current == ({5'h0, pump_up_code} + pump_down_code) * gq(pump_multiplier))
    else $error("loop current wrong");
  AST_MODE_FOLLOW: assert property (wr_mode_s |-> ##2 ext_mode == $past(pwdata[0], 2))
    else $error("mode not applied");
endmodule // pump_bank_asserts

bind pump_config_bank pump_bank_asserts #(.ADDR_W(ADDR_W)) pump_bank_asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_mode(ext_mode), .pump_up_code(pump_up_code), .pump_down_code(pump_down_code),
  .pump_multiplier(pump_multiplier), .loop_current(loop_current),
  .pump_up_off(pump_up_off), .pump_down_off(pump_down_off),
  .pump_code_mismatch(pump_code_mismatch));

// [testbench/tb_top.sv]
`timescale 1ns/10ps

module tb_top;
  logic               pclk = 1'b0, presetn = 1'b0;
  logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0]         paddr = 10'h0;
  logic [31:0]        pwdata = 32'h0, prdata;
  logic               pready, pslverr, ext_mode, up_off, down_off, code_mm;
  pump_pkg::code_t    up_code, down_code;
  pump_pkg::mult_t    mult;
  pump_pkg::current_t loop_cur;
  int                 mismatches = 0, checks = 0;
  int                 seed = 32'hd4957c45;
  logic [33:0]        notes[$];
  logic [33:0]        note;
  logic [25:0]        pump_notes[$];
  logic [25:0]        pump_got;
  logic [4:0]         iu, idn, eu, ed, au, ad;
  logic [1:0]         im, em, am;
  logic               md;

  always #2 pclk = ~pclk;

  pump_config_bank #(.ADDR_W(10)) pump_config_bank_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_mode(ext_mode), .pump_up_code(up_code), .pump_down_code(down_code),
    .pump_multiplier(mult), .loop_current(loop_cur), .pump_up_off(up_off),
    .pump_down_off(down_off), .pump_code_mismatch(code_mm));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [32:0] exp, input logic [32:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask

  task automatic cmp_pump(input logic [25:0] exp, input logic [25:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask

  function automatic logic [3:0] gain(input logic [1:0] m);
    case (m)
      2'h0: return 4'h4;
      2'h1: return 4'h8;
      2'h2: return 4'h6;
      default: return 4'ha;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus driver and result monitor
  // ----------------------------------------------------------------
  // Idle cycle after each transfer keeps one assignment per time step
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    notes.push_back({~wr, exp});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h0, {17'h0, e});
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      note = notes.pop_front();
      if (note[33]) cmp(note[32:0], {pslverr, prdata});
      else cmp({note[32], 32'h0}, {pslverr, 32'h0});
      if (note[33] && paddr == 10'h0ac) begin
        pump_got = {ext_mode, up_code, down_code, mult, up_off, down_off, code_mm, loop_cur};
        cmp_pump(pump_notes.pop_front(), pump_got);
      end
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(10'h0a0, 16'h101c);
    rd(10'h0a4, 16'h0810);
    rd(10'h0a8, 16'h0210);
    pump_notes.push_back({1'b0, 5'h10, 5'h10, 2'h0, 3'h0, 10'h080});
    rd(10'h0ac, 16'h0080);
    apb(1'b0, 10'h3fc, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 10'h3f8, 32'h1234, {1'b1, 32'h0});
    $display("test reset_and_map done");
    for (int i = 0; i < 8; i++) begin
      md = i[0];
      im = i[2:1];
      em = im + 2'h1;
      iu = 5'($random(seed));
      // equal internal codes on every third pass
      idn = (i % 3 == 0) ? iu : 5'($random(seed));
      eu = {4'($random(seed)), 1'b0};
      ed = (i % 3 == 1) ? eu + 5'h2 : eu;
      if (i == 2) iu = 5'h0;
      if (i == 3) ed = 5'h0;
      apb(1'b1, 10'h0a0, {19'h0, iu, im, 6'h1c}, 33'h0);
      apb(1'b1, 10'h0a4, {20'h0, eu, em, idn}, 33'h0);
      apb(1'b1, 10'h0a8, {26'h8, 1'b0, ed}, 33'h0);
      apb(1'b1, 10'h0b0, {31'h0, md}, 33'h0);
      // Pump stage lags the write edge by one edge
      repeat (3) @(posedge pclk);
      au = md ? eu : iu;
      ad = md ? ed : idn;
      am = md ? em : im;
      pump_notes.push_back({md, au, ad, am, au == 5'h0, ad == 5'h0, au != ad,
                            10'(({5'h0, au} + ad) * gain(am))});
      rd(10'h0ac, {2'h0, ad == 5'h0, au == 5'h0, au != ad, md,
                   10'(({5'h0, au} + ad) * gain(am))});
      rd(10'h0a0, {3'h0, iu, im, 6'h1c});
      rd(10'h0a4, {4'h0, eu, em, idn});
      rd(10'h0a8, {10'h008, 1'b0, ed});
    end
    $display("test pump_settings done");
    // Reserved upper bits written as zero; upper bus half is ignored
    apb(1'b1, 10'h0a4, 32'hffff0fff, 33'h0);
    rd(10'h0a4, 16'h0fff);
    $display("test full_width done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    pump_notes.push_back({1'b0, 5'h10, 5'h10, 2'h0, 3'h0, 10'h080});
    rd(10'h0ac, 16'h0080);
    rd(10'h0a4, 16'h0810);
    rd(10'h0a0, 16'h101c);
    rd(10'h0b0, 16'h0000);
    $display("test mid_reset done");
    end_of_test();
  end

  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
endmodule // tb_top
